// ===== gihc_params.svh
// Purpose: constants for the gyro interrupt hold control block
// Assumes: 40 MHz reference clock, word-indexed registers on the bus
// Notes: register indices times four give the byte address
`ifndef GIHC_PARAMS_SVH
`define GIHC_PARAMS_SVH

// ----------------------------------------
// register indices and reset values
// ----------------------------------------
`define GIHC_IDX_FIFO_CFG 8'h1E
`define GIHC_IDX_HOLD_CTRL 8'h21
`define GIHC_IDX_IRQ_STATE 8'h30
`define GIHC_FIFO_CFG_RST 8'h88
`define GIHC_HOLD_CTRL_RST 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define GIHC_FIFO_EN_BIT 7
`define GIHC_STAT_CLR_BIT 7
`define GIHC_OFS_CLR_BIT 6
`define GIHC_LATCH_STAT_BIT 4
`define GIHC_MODE_MSB 3

// ----------------------------------------
// timing: clock rate and hold times in microseconds
// ----------------------------------------
`define GIHC_CLK_MHZ 40
`define GIHC_T_250US 32'h000000FA
`define GIHC_T_500US 32'h000001F4
`define GIHC_T_1MS 32'h000003E8
`define GIHC_T_12MS5 32'h000030D4
`define GIHC_T_25MS 32'h000061A8
`define GIHC_T_50MS 32'h0000C350
`define GIHC_T_250MS 32'h0003D090
`define GIHC_T_500MS 32'h0007A120
`define GIHC_T_1S 32'h000F4240
`define GIHC_T_2S 32'h001E8480
`define GIHC_T_4S 32'h003D0900
`define GIHC_T_8S 32'h007A1200

`endif

// ===== gihc_pkg.sv
// Purpose: types and hold-mode decoding for the interrupt hold control
// Assumes: hold times counted in microsecond ticks
// Notes: decoding is shared by every interrupt channel
`include "gihc_params.svh"

package gihc_pkg;

  // ----------------------------------------
  // hold behaviour of an interrupt output
  // ----------------------------------------
  typedef enum logic [1:0] {GIHC_NONLATCH, GIHC_TEMP, GIHC_LATCH} gihc_kind_type;

  // kind of holding for a four-bit mode code
  function automatic gihc_kind_type gihc_kind(input logic [3:0] mode);
    gihc_kind_type k;
    k = GIHC_TEMP;
    case (mode)
      4'h0, 4'h8: k = GIHC_NONLATCH;
      4'h7, 4'hF: k = GIHC_LATCH;
      default: k = GIHC_TEMP;
    endcase
    return k;
  endfunction

  // hold time in microsecond ticks for a temporary mode code
  function automatic logic [31:0] gihc_hold_us(input logic [3:0] mode);
    logic [31:0] t;
    t = 32'h00000000;
    case (mode)
      4'h1: t = `GIHC_T_250MS;
      4'h2: t = `GIHC_T_500MS;
      4'h3: t = `GIHC_T_1S;
      4'h4: t = `GIHC_T_2S;
      4'h5: t = `GIHC_T_4S;
      4'h6: t = `GIHC_T_8S;
      4'h9: t = `GIHC_T_250US;
      4'hA: t = `GIHC_T_500US;
      4'hB: t = `GIHC_T_1MS;
      4'hC: t = `GIHC_T_12MS5;
      4'hD: t = `GIHC_T_25MS;
      4'hE: t = `GIHC_T_50MS;
      default: t = 32'h00000000;
    endcase
    return t;
  endfunction

endpackage

// ===== gihc_hold_chan.sv
// Purpose: one interrupt output with selectable holding
// Assumes: tick is a one-cycle pulse every microsecond
// Notes: a new event always wins over a clear in the same cycle
`timescale 1ns/1ps
`include "gihc_params.svh"

module gihc_hold_chan
  import gihc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic srcEvent,
  input wire logic clear,
  input wire logic tick,
  input wire logic [3:0] mode,
  output logic irqOut
);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  gihc_kind_type kind;
  logic [31:0] loadTicks;
  logic [31:0] holdCnt_reg;
  logic irq_reg;
  assign kind = gihc_kind(mode);
  assign loadTicks = gihc_hold_us(mode);
  assign irqOut = irq_reg;

  // ----------------------------------------
  // hold state
  // ----------------------------------------
  // event first so a clear in the same cycle never loses it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_reg <= 1'b0;
      holdCnt_reg <= 32'h00000000;
    end
    else if (srcEvent)
    begin
      irq_reg <= 1'b1;
      holdCnt_reg <= loadTicks;
    end
    else if (clear)
    begin
      irq_reg <= 1'b0;
      holdCnt_reg <= 32'h00000000;
    end
    else
    begin
      case (kind)
        GIHC_NONLATCH: irq_reg <= 1'b0;
        GIHC_LATCH: irq_reg <= irq_reg;
        GIHC_TEMP:
        begin
          if (tick && irq_reg)
          begin
            if (holdCnt_reg <= 32'h00000001)
            begin
              irq_reg <= 1'b0;
              holdCnt_reg <= 32'h00000000;
            end
            else
            begin
              holdCnt_reg <= holdCnt_reg - 32'h00000001;
            end
          end
        end
        default: irq_reg <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_nonlatch_follow;
    @(posedge ref_clk) disable iff (!rstn)
      (kind == GIHC_NONLATCH) |=> (irqOut == $past(srcEvent));
  endproperty
  a_nonlatch_follow: assert property (p_nonlatch_follow) else $error("nonlatched output not following source");

  property p_latch_keep;
    @(posedge ref_clk) disable iff (!rstn)
      (kind == GIHC_LATCH && irqOut && !clear) |=> irqOut;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latched interrupt dropped without clear");

  property p_clear_drops;
    @(posedge ref_clk) disable iff (!rstn)
      (clear && !srcEvent) |=> !irqOut;
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("interrupt survived a status clear");

  property p_temp_load;
    @(posedge ref_clk) disable iff (!rstn)
      (kind == GIHC_TEMP && srcEvent) |=> (irqOut && holdCnt_reg == $past(loadTicks));
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("temporary hold not loaded with its time");

endmodule

// ===== gihc_top.sv
// Purpose: interrupt hold and clear control with AHB-Lite register access
// Assumes: single word transfers, inputs synchronous to ref_clk
// Notes: byte address is four times the register index
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gihc_params.svh"

// Contract
// - fifo level interrupt passes only while enable bit 7 of config is one
// - writing one to hold-control bit 7 clears every interrupt status
// - writing one to hold-control bit 6 clears quick and gradual bias offsets
// - mode 0000b or 1000b gives non-latched interrupt outputs
// - modes 0001b to 0110b hold 250 ms, 500 ms, 1 s, 2 s, 4 s, 8 s
// - modes 0111b and 1111b latch the interrupt
// - modes 1001b to 1110b hold 250 us, 500 us, 1 ms, 12.5, 25, 50 ms
module gihc_top
  import gihc_pkg::*;
#(
  parameter int NSRC = 4,
  parameter int FIFO_SRC = 0,
  parameter int TICK_CYCLES = `GIHC_CLK_MHZ
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NSRC-1:0] srcEvent,
  output logic [NSRC-1:0] irqOut,
  output logic srcStatusClear,
  output logic quickBiasCorrectionClear,
  output logic gradualBiasCorrectionClear,
  output logic latchStatus
);

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic wrPend_reg;
  logic rdPend_reg;
  logic [7:0] wrIdx_reg;
  logic [7:0] rdIdx_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic rdDone_reg;
  wire addrOk;
  wire inRange;
  wire [7:0] addrIdx;
  wire wrAccept;
  wire rdAccept;

  // size is not checked: only whole words are ever issued
  assign inRange = (haddr[31:10] == 22'h000000);
  assign addrIdx = inRange ? haddr[9:2] : 8'hFF;
  assign addrOk = hsel && hready && htrans[1];
  assign wrAccept = addrOk && hwrite;
  assign rdAccept = addrOk && !hwrite;

  // reads take one wait state so the data comes from a flop
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      wrIdx_reg <= 8'h00;
      rdIdx_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      rdDone_reg <= 1'b0;
    end
    else
    begin
      wrPend_reg <= wrAccept;
      rdPend_reg <= rdAccept;
      wrIdx_reg <= wrAccept ? addrIdx : wrIdx_reg;
      rdIdx_reg <= rdAccept ? addrIdx : rdIdx_reg;
      hreadyout_reg <= !rdAccept;
      rdDone_reg <= rdPend_reg;
    end
  end

  // ----------------------------------------
  // register write decode
  // ----------------------------------------
  logic [7:0] fifoCfg_reg;
  logic [7:0] holdCtrl_reg;
  logic statClr_reg;
  logic ofsClr_reg;
  wire wrFifo;
  wire wrHold;
  wire [7:0] fifoCfg_next;
  wire [7:0] holdCtrl_next;
  wire statClr_next;
  wire ofsClr_next;

  // command bits are never stored, so they read back as zero
  assign wrFifo = wrPend_reg && (wrIdx_reg == `GIHC_IDX_FIFO_CFG);
  assign wrHold = wrPend_reg && (wrIdx_reg == `GIHC_IDX_HOLD_CTRL);
  assign fifoCfg_next = wrFifo ? hwdata[7:0] : fifoCfg_reg;
  assign holdCtrl_next = wrHold ? {3'h0, hwdata[`GIHC_LATCH_STAT_BIT],
    hwdata[`GIHC_MODE_MSB:0]} : holdCtrl_reg;
  assign statClr_next = wrHold && hwdata[`GIHC_STAT_CLR_BIT];
  assign ofsClr_next = wrHold && hwdata[`GIHC_OFS_CLR_BIT];

  // registers and one-cycle command pulses
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fifoCfg_reg <= `GIHC_FIFO_CFG_RST;
      holdCtrl_reg <= `GIHC_HOLD_CTRL_RST;
      statClr_reg <= 1'b0;
      ofsClr_reg <= 1'b0;
    end
    else
    begin
      fifoCfg_reg <= fifoCfg_next;
      holdCtrl_reg <= holdCtrl_next;
      statClr_reg <= statClr_next;
      ofsClr_reg <= ofsClr_next;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] rdMux;
  wire [31:0] irqWord;
  assign irqWord = {{(32-NSRC){1'b0}}, irqOut};
  assign rdMux = (rdIdx_reg == `GIHC_IDX_FIFO_CFG) ? {24'h000000, fifoCfg_reg} :
    (rdIdx_reg == `GIHC_IDX_HOLD_CTRL) ? {24'h000000, holdCtrl_reg} :
    (rdIdx_reg == `GIHC_IDX_IRQ_STATE) ? irqWord : 32'h00000000;

  // data held until the wait state of the next read reloads it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hrdata_reg <= 32'h00000000;
    end
    else if (rdPend_reg)
    begin
      hrdata_reg <= rdMux;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ----------------------------------------
  // microsecond tick
  // ----------------------------------------
  logic [31:0] tickCnt_reg;
  logic tick_reg;
  wire tickWrap;
  assign tickWrap = (tickCnt_reg >= 32'(TICK_CYCLES - 1));

  // one shared prescaler keeps each channel counter in microseconds
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tickCnt_reg <= tickWrap ? 32'h00000000 : tickCnt_reg + 32'h00000001;
      tick_reg <= tickWrap;
    end
  end

  // ----------------------------------------
  // interrupt channels
  // ----------------------------------------
  wire fifoEnable;
  wire [NSRC-1:0] gatedEvent;
  assign fifoEnable = fifoCfg_reg[`GIHC_FIFO_EN_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_chan
      // fifo level source is masked by its enable bit
      assign gatedEvent[gi] = (gi == FIFO_SRC) ? (srcEvent[gi] && fifoEnable)
        : srcEvent[gi];
      gihc_hold_chan u_chan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .srcEvent(gatedEvent[gi]),
        .clear(statClr_reg),
        .tick(tick_reg),
        .mode(holdCtrl_reg[`GIHC_MODE_MSB:0]),
        .irqOut(irqOut[gi])
      );
    end
  endgenerate

  assign srcStatusClear = statClr_reg;
  assign quickBiasCorrectionClear = ofsClr_reg;
  assign gradualBiasCorrectionClear = ofsClr_reg;
  assign latchStatus = holdCtrl_reg[`GIHC_LATCH_STAT_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_hold_cmd_bit7;
    wrHold && hwdata[`GIHC_STAT_CLR_BIT];
  endsequence

  sequence s_pulse_once;
    srcStatusClear ##1 !srcStatusClear;
  endsequence

  property p_stat_clr_pulse;
    @(posedge ref_clk) disable iff (!rstn)
      s_hold_cmd_bit7 ##1 !wrHold |-> s_pulse_once;
  endproperty
  a_stat_clr_pulse: assert property (p_stat_clr_pulse) else $error("status clear not a single pulse");

  property p_ofs_clr;
    @(posedge ref_clk) disable iff (!rstn)
      (wrHold && hwdata[`GIHC_OFS_CLR_BIT]) |=>
        (quickBiasCorrectionClear && gradualBiasCorrectionClear);
  endproperty
  a_ofs_clr: assert property (p_ofs_clr) else $error("offset clear not issued");

  property p_fifo_gate;
    @(posedge ref_clk) disable iff (!rstn)
      (!fifoEnable && gihc_kind(holdCtrl_reg[3:0]) == GIHC_NONLATCH && !wrFifo)
        |=> !irqOut[FIFO_SRC];
  endproperty
  a_fifo_gate: assert property (p_fifo_gate) else $error("fifo interrupt raised while disabled");

  property p_hold_rd_zero;
    @(posedge ref_clk) disable iff (!rstn)
      (rdDone_reg && rdIdx_reg == `GIHC_IDX_HOLD_CTRL) |-> (hrdata[7:5] == 3'h0);
  endproperty
  a_hold_rd_zero: assert property (p_hold_rd_zero) else $error("command bits read back non-zero");

  property p_read_wait;
    @(posedge ref_clk) disable iff (!rstn)
      rdAccept |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule

// ===== gihc_host_model.sv
// Purpose: host model issuing single AHB-Lite word transfers
// Assumes: one slave, whose hreadyout is fed back as hready
// Notes: the bench calls xfer by hierarchical name; no burst support
`timescale 1ns/1ps

module gihc_host_model
(
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ----------------------------------------
  // idle bus from time zero
  // ----------------------------------------
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  // ----------------------------------------
  // one transfer; caller keeps reserved bits and reserved indices out
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    hsize <= 3'h2;
    // address phase held until the slave takes it
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    // data phase held until the answer; read data taken at that edge
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

// ===== gyro_interrupt_hold_control_bench.sv
// Purpose: self-checking bench for the interrupt hold control block
// Assumes: one microsecond tick per clock, so hold codes map to cycles
// Notes: long hold codes are only checked to be still holding
`timescale 1ns/1ps

module gyro_interrupt_hold_control_bench;
  import gihc_pkg::*;

  logic clk, rstn, hsel, hwrite, hreadyout, hresp, stClr, qClr, gClr, latchSt, en;
  logic [31:0] haddr, hwdata, hrdata, rd, e;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [3:0] srcEvent, irqOut;
  logic [7:0] m;
  int errCount, nChecks, seed, nStClr, nQ, nG, k, j, t;

  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  gihc_top #(.NSRC(4), .FIFO_SRC(0), .TICK_CYCLES(1)) DUT (.ref_clk(clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .srcEvent(srcEvent), .irqOut(irqOut), .srcStatusClear(stClr),
    .quickBiasCorrectionClear(qClr), .gradualBiasCorrectionClear(gClr),
    .latchStatus(latchSt));

  gihc_host_model host (.ref_clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // count command pulses so their width is checked, not only presence
  always @(posedge clk)
  begin
    nStClr <= nStClr + int'(stClr === 1'b1);
    nQ <= nQ + int'(qClr === 1'b1);
    nG <= nG + int'(gClr === 1'b1);
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h00000000, got}, {31'h00000000, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle event; returns just after the edge that sampled it
  task automatic fire(input int ch);
    @(posedge clk);
    srcEvent[ch] <= 1'b1;
    @(posedge clk);
    srcEvent[ch] <= 1'b0;
    #1;
  endtask

  // expected hold time in microseconds of a temporary code
  function automatic int hold_us(input logic [3:0] c);
    if (c < 4'h7) return 250000 << (c - 1);
    if (c < 4'hC) return 250 << (c - 9);
    return 12500 << (c - 12);
  endfunction

  task automatic give_verdict();
    if (errCount == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, well beyond the planned run length
  initial
  begin
    #(25 * 60000);
    errCount++;
    give_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rstn = 1'b0;
    srcEvent = 4'h0;
    seed = 11;
    {errCount, nChecks, nStClr, nQ, nG} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // reset values and an unmapped place
    host.xfer(1'b0, 8'h1E, 8'h00, rd);
    chk_reg(rd, 32'h00000088);
    chk_bit(hresp, 1'b0);
    host.xfer(1'b0, 8'h21, 8'h00, rd);
    chk_reg(rd, 32'h00000000);
    host.xfer(1'b0, 8'h3F, 8'h00, rd);
    chk_reg(rd, 32'h00000000);
    // fifo level source gated by its enable
    host.xfer(1'b1, 8'h1E, 8'h00, rd);
    fire(0);
    chk_bit(irqOut[0], 1'b0);
    host.xfer(1'b1, 8'h1E, 8'h80, rd);
    fire(0);
    chk_bit(irqOut[0], 1'b1);
    // both non-latched codes follow the source
    for (int i = 0; i < 2; i++)
    begin
      host.xfer(1'b1, 8'h21, i ? 8'h08 : 8'h00, rd);
      fire(1);
      chk_bit(irqOut[1], 1'b1);
      cyc(2);
      chk_bit(irqOut[1], 1'b0);
    end
    // both latched codes hold until the status clear
    for (int i = 0; i < 2; i++)
    begin
      m = i ? 8'h0F : 8'h07;
      host.xfer(1'b1, 8'h21, m, rd);
      fire(2);
      cyc(20 + ($random(seed) & 63));
      chk_bit(irqOut[2], 1'b1);
      host.xfer(1'b0, 8'h30, 8'h00, rd);
      chk_reg(rd, 32'h00000004);
      k = nStClr;
      host.xfer(1'b1, 8'h21, 8'h80 | m, rd);
      cyc(2);
      chk_bit(irqOut[2], 1'b0);
      chk_reg(nStClr - k, 1);
      host.xfer(1'b0, 8'h21, 8'h00, rd);
      chk_reg(rd, {24'h000000, m});
    end
    // offset clear pulses once on both outputs, mode back to non-latched
    k = nQ;
    j = nG;
    host.xfer(1'b1, 8'h21, 8'h50, rd);
    cyc(2);
    chk_reg(nQ - k, 1);
    chk_reg(nG - j, 1);
    chk_bit(latchSt, 1'b1);
    host.xfer(1'b0, 8'h21, 8'h00, rd);
    chk_reg(rd, 32'h00000010);
    // random source traffic in non-latched mode with the enable toggling
    for (int i = 0; i < 40; i++)
    begin
      e = $random(seed);
      if (i % 8 == 0)
      begin
        en = e[31];
        host.xfer(1'b1, 8'h1E, {en, 7'h00}, rd);
      end
      @(posedge clk);
      srcEvent <= e[3:0];
      cyc(1);
      chk_reg({28'h0000000, irqOut}, {28'h0000000, e[3:1], e[0] & en});
    end
    @(posedge clk);
    srcEvent <= 4'h0;
    // every temporary code: short ones timed on both sides
    for (int c = 1; c < 15; c++)
    begin
      if (c == 7 || c == 8) continue;
      host.xfer(1'b1, 8'h21, 8'h80 | c[7:0], rd);
      t = hold_us(c[3:0]);
      fire(3);
      cyc((t < 1500) ? t - 3 : 1200);
      chk_bit(irqOut[3], 1'b1);
      if (t < 1500)
      begin
        cyc(6);
        chk_bit(irqOut[3], 1'b0);
      end
    end
    give_verdict();
  end
endmodule
